// ==== verilog/bus_handshake_pkg.sv ====
// Constants and types shared by both ends of the bus-mastership handshake.
// Assumes one core clock for all logic and active-low request, grant, lock and busy lines.
`default_nettype none
package bus_handshake_pkg;
    // Register offsets of the device's own control and status words
    localparam logic [7:0] CTRL_OFFSET      = 8'h00;
    localparam logic [7:0] STATUS_OFFSET    = 8'h04;
    // Control word field positions
    localparam int         CTRL_REQ_HOLD    = 0;
    localparam int         CTRL_LOCK_HOLD   = 1;
    localparam int         CTRL_SLOW_REL    = 2;
    localparam int         CTRL_PORT_DIS    = 3;
    localparam logic [3:0] CTRL_RESET       = 4'h0;
    // Status word field positions
    localparam int         STAT_MASTER      = 0;
    localparam int         STAT_GRANT       = 1;
    localparam int         STAT_BUSY        = 2;
    // Cycles one external access occupies the port
    localparam int         ACCESS_CYCLES    = 2;
    localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MASTER,
        ST_ACCESS,
        ST_REL_HIGH,
        ST_REL_SLOW
    } dev_state_t;
endpackage
`default_nettype wire

// ==== verilog/bus_handshake_if.sv ====
// Link between the device end and the arbiter end.
// The shared busy line is open drain with a pull-up; other masters pull it
// low through busy_other_low, which the surroundings drive.
`default_nettype none
interface bus_handshake_if;
    logic bus_request_n;
    logic bus_grant_n;
    logic bus_lock_n;
    logic bus_busy_drv;
    logic bus_busy_oe;
    logic busy_other_low;
    logic bus_busy_n;

    // Pull-up wins unless someone drives the line
    assign bus_busy_n = (bus_busy_oe && !bus_busy_drv) ? 1'b0 :
                        (busy_other_low ? 1'b0 : 1'b1);

    modport device (
        output bus_request_n,
        output bus_lock_n,
        output bus_busy_drv,
        output bus_busy_oe,
        input  bus_grant_n,
        input  bus_busy_n
    );
    modport arbiter (
        input  bus_request_n,
        output bus_grant_n
    );
endinterface
`default_nettype wire

// ==== verilog/bus_arbiter_end.sv ====
// Central arbiter end: fixed priority, device at index 0 is highest.
// Assumes the same core clock as the device; other requesters are plain ports.
`default_nettype none
module bus_arbiter_end
    import bus_handshake_pkg::*;
#(
    parameter int N_OTHERS    = 2,
    parameter bit PARK_EN     = 1'b1,
    parameter int DEFAULT_IDX = 0
) (
    input  wire logic                clk_sys_in,
    input  wire logic                resetn_in,
    bus_handshake_if.arbiter         link,
    input  wire logic [N_OTHERS-1:0] other_request_n_in,
    output logic      [N_OTHERS-1:0] other_grant_n_out
);
    localparam int N = N_OTHERS + 1;

    typedef struct packed {
        logic [N-1:0] grant;
    } arb_state_t;

    arb_state_t   st_reg;
    arb_state_t   st_next;
    logic [N-1:0] req;

    // Lowest index wins
    function automatic logic [N-1:0] pick_first(input logic [N-1:0] r);
        logic [N-1:0] g;
        g = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (r[i]) begin
                g = '0;
                g[i] = 1'b1;
            end
        end
        return g;
    endfunction

    assign req = {~other_request_n_in, ~link.bus_request_n};

    always_comb begin
        st_next = st_reg;
        if (|req) begin
            st_next.grant = pick_first(req);
        end else if (!PARK_EN) begin
            st_next.grant = '0;
            st_next.grant[DEFAULT_IDX] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.bus_grant_n  = ~st_reg.grant[0];
    assign other_grant_n_out = ~st_reg.grant[N-1:1];
endmodule
`default_nettype wire

// ==== verilog/bus_master_handshake.sv ====
// Device end: requests, claims, holds and releases the shared external bus.
// Assumes an AHB-Lite master for its control word and a core that presents
// one external access at a time with valid/ready.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`default_nettype none
// Functional notes
// - Request held while bus is needed
// - Grant counts only while busy free
// - Drive busy high, then release it
// - Claim busy only after seeing it free
// - Arbiter moves grant, one at most
// - Transfers start after busy asserted
// - Arbiter may withdraw grant any time
// - Finish current access, then release
// - Lock and hold bus through RMW
// - Packing, bit-modify, bursts are indivisible
// - Request-hold bit keeps request on
// - Lock-hold bit keeps lock on
// - Read-only mastership status bit
// - Fast release frees all pins together
// - Slow release frees busy one cycle later
// - Low-power release, grant ignored
// - Parked owner keeps bus without request
// - Arbiter grants highest priority first
// - Default grant alone never claims; claim needs a pending access
// - Arbitration overlaps ongoing transfers
// - Port disable releases bus, ignores grant
module bus_master_handshake
    import bus_handshake_pkg::*;
#(
    parameter int ACC_CYCLES = ACCESS_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    bus_handshake_if.device  link,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Core access port
    input  wire logic        acc_valid_in,
    input  wire logic        acc_rmw_in,
    input  wire logic        acc_last_in,
    input  wire logic        low_power_in,
    output logic             acc_ready_out,
    output logic             acc_done_out,
    output logic             port_drive_out
);
    localparam int CW = $clog2(ACC_CYCLES + 1);

    typedef struct packed {
        dev_state_t  fsm;
        logic [2:0]  grant_sync;
        logic [2:0]  busy_sync;
        logic        grant_f;
        logic        busy_f;
        logic [CW-1:0] cnt;
        logic        in_group;
        logic        in_rmw;
        logic [3:0]  ctrl;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
        logic        done;
        logic        port_oe;
        logic        busy_oe;
        logic        busy_drv;
        logic        req_n;
        logic        lock_n;
    } dev_reg_t;

    dev_reg_t st_reg;
    dev_reg_t st_next;
    logic     addr_phase;
    logic     blocked;
    logic     granted;
    logic     is_master;
    logic     need_bus;

    function automatic logic [31:0] read_word(input logic [7:0] a, input dev_reg_t s,
                                              input logic m);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == CTRL_OFFSET) begin
            w[3:0] = s.ctrl;
        end else if (a == STATUS_OFFSET) begin
            w[STAT_MASTER] = m;
            w[STAT_GRANT]  = !s.grant_f;
            w[STAT_BUSY]   = !s.busy_f;
        end
        return w;
    endfunction

    assign addr_phase = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
    assign blocked    = low_power_in || st_reg.ctrl[CTRL_PORT_DIS];
    assign granted    = !st_reg.grant_f && !blocked;
    assign is_master  = (st_reg.fsm == ST_MASTER) || (st_reg.fsm == ST_ACCESS);
    assign need_bus   = acc_valid_in || st_reg.in_group;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.grant_sync = {st_reg.grant_sync[1:0], link.bus_grant_n};
        st_next.busy_sync  = {st_reg.busy_sync[1:0], link.bus_busy_n};
        if (st_reg.grant_sync[1] == st_reg.grant_sync[2]) begin
            st_next.grant_f = st_reg.grant_sync[2];
        end
        if (st_reg.busy_sync[1] == st_reg.busy_sync[2]) begin
            st_next.busy_f = st_reg.busy_sync[2];
        end

        // Register writes land in the data phase; reads are fetched in the address phase
        st_next.wr_pend = addr_phase && hwrite_in;
        if (addr_phase) begin
            st_next.wr_addr = haddr_in;
            st_next.rdata   = read_word(haddr_in, st_reg, is_master);
        end
        if (st_reg.wr_pend && st_reg.wr_addr == CTRL_OFFSET) begin
            st_next.ctrl = hwdata_in[3:0];
        end

        unique case (st_reg.fsm)
            ST_IDLE: begin
                if (granted && st_reg.busy_f && need_bus) begin
                    st_next.fsm      = ST_MASTER;
                    st_next.busy_oe  = 1'b1;
                    st_next.busy_drv = 1'b0;
                    st_next.port_oe  = 1'b1;
                end
            end
            ST_MASTER: begin
                if (acc_valid_in && acc_ready_out) begin
                    st_next.fsm      = ST_ACCESS;
                    st_next.cnt      = CW'(ACC_CYCLES);
                    // Group kept until its last access
                    st_next.in_group = !acc_last_in;
                    st_next.in_rmw   = acc_rmw_in || st_reg.in_rmw;
                end else if (!st_reg.in_group && (!granted || blocked)) begin
                    st_next.fsm      = ST_REL_HIGH;
                    st_next.busy_drv = 1'b1;
                end
            end
            ST_ACCESS: begin
                // Run the access to its end
                if (st_reg.cnt == CW'(1)) begin
                    st_next.fsm  = ST_MASTER;
                    st_next.done = 1'b1;
                    // Latched, so the core may drop its qualifiers after the take
                    st_next.in_rmw = st_reg.in_rmw && st_reg.in_group;
                end else begin
                    st_next.cnt = st_reg.cnt - CW'(1);
                end
            end
            ST_REL_HIGH: begin
                st_next.port_oe = 1'b0;
                if (st_reg.ctrl[CTRL_SLOW_REL]) begin
                    // Busy stays driven one more cycle
                    st_next.fsm = ST_REL_SLOW;
                end else begin
                    st_next.fsm     = ST_IDLE;
                    st_next.busy_oe = 1'b0;
                end
            end
            ST_REL_SLOW: begin
                st_next.fsm     = ST_IDLE;
                st_next.busy_oe = 1'b0;
            end
        endcase

        st_next.req_n  = !(!blocked && (need_bus || st_reg.ctrl[CTRL_REQ_HOLD]));
        // Lock during RMW or when held
        st_next.lock_n = !(!st_reg.ctrl[CTRL_PORT_DIS] &&
                           (st_reg.ctrl[CTRL_LOCK_HOLD] || st_next.in_rmw));
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg           <= '0;
            st_reg.fsm       <= ST_IDLE;
            st_reg.grant_sync <= 3'h7;
            st_reg.busy_sync <= 3'h7;
            st_reg.grant_f   <= 1'b1;
            st_reg.busy_f    <= 1'b1;
            st_reg.ctrl      <= CTRL_RESET;
            st_reg.busy_drv  <= 1'b1;
            st_reg.req_n     <= 1'b1;
            st_reg.lock_n    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Core access taken only while master and granted or mid-group
    assign acc_ready_out      = (st_reg.fsm == ST_MASTER) && (st_reg.in_group || granted);
    assign acc_done_out       = st_reg.done;
    assign port_drive_out     = st_reg.port_oe;
    assign link.bus_request_n = st_reg.req_n;
    assign link.bus_lock_n    = st_reg.lock_n;
    assign link.bus_busy_drv  = st_reg.busy_drv;
    assign link.bus_busy_oe   = st_reg.busy_oe;
    assign hrdata_out         = st_reg.rdata;
    // Zero wait states and always OKAY keep the slave trivial
    assign hreadyout_out      = 1'b1;
    assign hresp_out          = 1'b0;
endmodule
`default_nettype wire

// ==== dv/bus_handshake_assertions.sv ====
// Concurrent checks on the link between the device end and the arbiter.
// Assumes one core clock; instantiated beside the link interface.
`default_nettype none
module bus_handshake_assertions (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic bus_lock_n,
    input wire logic bus_busy_drv,
    input wire logic bus_busy_oe,
    input wire logic busy_other_low,
    input wire logic bus_busy_n
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    wire logic dev_low = bus_busy_oe && !bus_busy_drv;
    sequence s_drive_high;
        $rose(bus_busy_drv) && bus_busy_oe;
    endsequence
    // Busy must stay driven high until the pin is let go
    sequence s_pins_free;
        bus_busy_drv throughout (##[1:2] !bus_busy_oe);
    endsequence
    chk_claim_when_free: assert property ($rose(dev_low) |-> $past(bus_busy_n))
        else $error("busy claimed while the line was low");
    chk_claim_granted: assert property ($rose(dev_low) |-> $past(!bus_grant_n))
        else $error("busy claimed without a grant");
    chk_high_before_off: assert property ($fell(bus_busy_oe) |-> $past(bus_busy_drv))
        else $error("busy released without driving high");
    chk_release_bounded: assert property (s_drive_high |-> s_pins_free)
        else $error("busy not released in time");
    chk_idle_after_reset: assert property ($rose(resetn_in) |->
        bus_request_n && bus_lock_n && !bus_busy_oe)
        else $error("link outputs active after reset");
    chk_grant_to_top: assert property (!bus_request_n |-> ##[1:2] !bus_grant_n)
        else $error("top priority request not granted");
    chk_claim_bounded: assert property ((!bus_grant_n && bus_busy_n && !bus_request_n
        && !busy_other_low) [*6] |=> !bus_busy_n)
        else $error("granted device did not claim free bus");
    chk_unlock_on_free: assert property ($fell(bus_busy_oe) |-> bus_lock_n)
        else $error("bus released while locked");
    // Meant for read-modify-write lock; a software lock hold while master is not covered
    chk_locked_keeps_bus: assert property (dev_low && !bus_lock_n |=>
        dev_low || bus_lock_n)
        else $error("locked master let busy go");
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Bench joining the device end and the arbiter end through the link.
// Assumes a 25 MHz core clock; plays AHB master, core and other masters.
`default_nettype none
module testbench
    import bus_handshake_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_in, resetn_in, hsel, hwrite, hready, hresp, port_drive;
    logic        acc_valid, acc_rmw, acc_last, low_power, acc_ready, acc_done;
    logic [7:0]  haddr;
    logic [1:0]  htrans, other_req_n, other_gnt_n;
    logic [31:0] hwdata, hrdata, q;
    int          err_count, checks;
    // Selectors of the signals that wait_lvl can watch
    localparam int W_READY = 0, W_DONE = 1, W_PORT = 2, W_LOCK = 3, W_OE = 4;
    bus_handshake_if link ();
    bus_master_handshake u_bus_master_handshake (
        .clk_sys_in    (clk_sys_in),
        .resetn_in     (resetn_in),
        .link          (link.device),
        .hsel_in       (hsel),
        .haddr_in      (haddr),
        .htrans_in     (htrans),
        .hwrite_in     (hwrite),
        .hsize_in      (3'h2),
        .hwdata_in     (hwdata),
        .hready_in     (hready),
        .hrdata_out    (hrdata),
        .hreadyout_out (hready),
        .hresp_out     (hresp),
        .acc_valid_in  (acc_valid),
        .acc_rmw_in    (acc_rmw),
        .acc_last_in   (acc_last),
        .low_power_in  (low_power),
        .acc_ready_out (acc_ready),
        .acc_done_out  (acc_done),
        .port_drive_out(port_drive)
    );
    bus_arbiter_end u_bus_arbiter_end (
        .clk_sys_in        (clk_sys_in),
        .resetn_in         (resetn_in),
        .link              (link.arbiter),
        .other_request_n_in(other_req_n),
        .other_grant_n_out (other_gnt_n)
    );
    bus_handshake_assertions u_bus_handshake_assertions (
        .clk_sys_in    (clk_sys_in),
        .resetn_in     (resetn_in),
        .bus_request_n (link.bus_request_n),
        .bus_grant_n   (link.bus_grant_n),
        .bus_lock_n    (link.bus_lock_n),
        .bus_busy_drv  (link.bus_busy_drv),
        .bus_busy_oe   (link.bus_busy_oe),
        .busy_other_low(link.busy_other_low),
        .bus_busy_n    (link.bus_busy_n)
    );
    initial begin
        clk_sys_in = 1'h0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic watched(input int sel);
        case (sel)
            W_READY: return acc_ready;
            W_DONE:  return acc_done;
            W_PORT:  return port_drive;
            W_LOCK:  return link.bus_lock_n;
            default: return link.bus_busy_oe;
        endcase
    endfunction
    // Sampled on the falling edge, away from the launching edge
    task automatic wait_lvl(input int sel, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys_in);
            n++;
            if (n > 300) begin
                chk("wait", v, watched(sel));
                report_and_stop();
            end
        end while (watched(sel) !== v);
    endtask
    // Returns just after the rising edge at which hready is seen high
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (n > 300) begin
                chk("hready", 1'h1, hready);
                report_and_stop();
            end
        end while (hready !== 1'h1);
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        hsel   <= 1'h1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        chk("hresp", 1'h0, hresp);
    endtask
    task automatic master_is(input logic e);
        ahb(1'h0, STATUS_OFFSET, 32'h0);
        chk("master", e, q[STAT_MASTER]);
    endtask
    task automatic access(input logic rmw, input logic last);
        @(posedge clk_sys_in);
        acc_valid <= 1'h1;
        acc_rmw <= rmw;
        acc_last <= last;
        wait_lvl(W_READY, 1'h1);
        @(posedge clk_sys_in);
        acc_valid <= 1'h0;
        wait_lvl(W_DONE, 1'h1);
        chk("busy_at_done", 1'h0, link.bus_busy_n);
    endtask
    task automatic t_basic();
        ahb(1'h1, STATUS_OFFSET, 32'hF);
        master_is(1'h0);
        access(1'h0, 1'h1);
        repeat (4) @(posedge clk_sys_in);
        chk("request_n", 1'h1, link.bus_request_n);
        chk("parked_busy_n", 1'h0, link.bus_busy_n);
        master_is(1'h1);
        access(1'h1, 1'h0);
        chk("lock_n", 1'h0, link.bus_lock_n);
        access(1'h1, 1'h1);
        wait_lvl(W_LOCK, 1'h1);
        $display("basic and rmw done");
    endtask
    // Slow release must leave busy as the last pin driven
    task automatic t_release(input logic slow);
        ahb(1'h1, CTRL_OFFSET, {29'h0, slow, 2'h0});
        access(1'h0, 1'h1);
        @(posedge clk_sys_in);
        other_req_n <= 2'h2;
        wait_lvl(W_PORT, 1'h0);
        chk("oe_at_port_off", slow, link.bus_busy_oe);
        @(negedge clk_sys_in);
        chk("oe_after", 1'h0, link.bus_busy_oe);
        chk("other_grant_n", 1'h0, other_gnt_n[0]);
        master_is(1'h0);
        other_req_n <= 2'h3;
        $display("release %0d done", slow);
    endtask
    task automatic t_priority();
        @(posedge clk_sys_in);
        link.busy_other_low <= 1'h1;
        acc_valid <= 1'h1;
        repeat (10) @(posedge clk_sys_in);
        chk("no_claim_oe", 1'h0, link.bus_busy_oe);
        chk("grant_n", 1'h0, link.bus_grant_n);
        ahb(1'h0, STATUS_OFFSET, 32'h0);
        chk("grant_seen", 1'h1, q[STAT_GRANT]);
        chk("busy_seen", 1'h1, q[STAT_BUSY]);
        link.busy_other_low <= 1'h0;
        access(1'h0, 1'h1);
        @(posedge clk_sys_in);
        other_req_n <= 2'h2;
        wait_lvl(W_OE, 1'h0);
        @(posedge clk_sys_in);
        link.busy_other_low <= 1'h1;
        ahb(1'h1, CTRL_OFFSET, 32'h3);
        repeat (4) @(posedge clk_sys_in);
        chk("hold_request_n", 1'h0, link.bus_request_n);
        chk("hold_lock_n", 1'h0, link.bus_lock_n);
        ahb(1'h0, CTRL_OFFSET, 32'h0);
        chk("ctrl_lock_hold", 1'h1, q[CTRL_LOCK_HOLD]);
        ahb(1'h1, CTRL_OFFSET, 32'h0);
        repeat (4) @(posedge clk_sys_in);
        chk("free_lock_n", 1'h1, link.bus_lock_n);
        link.busy_other_low <= 1'h0;
        other_req_n <= 2'h3;
        $display("priority and holds done");
    endtask
    task automatic t_block(input logic dis);
        ahb(1'h1, CTRL_OFFSET, {28'h0, dis, 3'h0});
        low_power <= !dis;
        acc_valid <= 1'h1;
        repeat (8) @(posedge clk_sys_in);
        chk("blocked_request_n", 1'h1, link.bus_request_n);
        chk("blocked_oe", 1'h0, link.bus_busy_oe);
        low_power <= 1'h0;
        acc_valid <= 1'h0;
        $display("block %0d done", dis);
    endtask
    initial begin
        {resetn_in, hsel, hwrite, acc_valid, acc_rmw, acc_last, low_power} = '0;
        {haddr, htrans, hwdata, err_count, checks} = '0;
        other_req_n = 2'h3;
        link.busy_other_low = 1'h0;
        repeat (6) @(posedge clk_sys_in);
        resetn_in <= 1'h1;
        @(negedge clk_sys_in);
        chk("reset_request_n", 1'h1, link.bus_request_n);
        t_basic();
        t_release(1'h0);
        t_release(1'h1);
        t_priority();
        t_block(1'h0);
        t_block(1'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
